// ### bench/sclk_osc_model.sv
// Behavioural oscillator sources on the far side of the clock select block
`timescale 1ns/1ps
module sclk_osc_model #(
  parameter int PRI_PER  = 3,  // Primary period in pclk cycles
  parameter int TMR_PER  = 7,  // Timer oscillator period
  parameter int FAST_PER = 2,  // Fast internal period
  parameter int SLOW_PER = 5   // Slow RC period
) (
  input  wire logic pclk,     // Clock
  input  wire logic presetn,  // Reset, active low
  input  wire logic tmr_on,   // Timer oscillator enabled
  output logic      pri_t,    // Primary edge
  output logic      tmr_t,    // Timer oscillator edge
  output logic      fast_t,   // Fast internal edge
  output logic      slow_t    // Slow RC edge
);
  int cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 1;
    else
      cnt_q <= cnt_q + 1;
  end
  // Three source classes; timer oscillator is silent unless enabled
  assign pri_t  = (cnt_q % PRI_PER) == 0;
  assign tmr_t  = tmr_on && (cnt_q % TMR_PER) == 0;
  assign fast_t = (cnt_q % FAST_PER) == 0;
  assign slow_t = (cnt_q % SLOW_PER) == 0;
endmodule : sclk_osc_model

// ### bench/sclk_properties.sv
// Port-level assertions for the clock select block
`timescale 1ns/1ps
module sclk_properties
  import sclk_pkg::*;
(
  input wire logic       pclk,                     // Clock
  input wire logic       presetn,                  // Reset, active low
  input wire logic       ce,                       // Clock enable
  input wire logic       psel,                     // APB select
  input wire logic       penable,                  // APB enable
  input wire logic       pready,                   // APB ready
  input wire logic       slow_rc_osc_tick,         // Slow RC edge
  input wire logic       wdt_failsafe_clock_monitor_tick,            // Watchdog edge
  input wire logic       sleep_cmd,                // Sleep pulse
  input wire logic       enter_idle,               // Idle entry
  input wire logic       enter_sleep,              // Sleep entry
  input wire logic       startup_timer_done_flag,  // Primary up
  input wire logic       timer_osc_running_flag,   // Timer osc used
  input wire logic [1:0] active_source,            // Source in use
  input wire logic       clock_hold                // Switch pause
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------
  // Bus answer, source switching, watchdog, sleep and running flags
  // ------------------------------
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_release;
    ##[1:300] !clock_hold;
  endsequence
  a_apb_zero_wait: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_switch_bounded: assert property ($rose(clock_hold) |-> s_release)
    else $error("clock pause does not end");
  a_switch_paused: assert property ($changed(active_source) |-> clock_hold)
    else $error("source changed outside a pause");
  a_no_reserved: assert property (active_source != SRC_RESERVED)
    else $error("reserved source in use");
  a_reset_primary: assert property ($rose(presetn) |-> active_source == SRC_PRIMARY)
    else $error("not on primary after reset");
  a_wdt_from_rc: assert property
    ($past(presetn) && $past(ce) |-> wdt_failsafe_clock_monitor_tick == $past(slow_rc_osc_tick))
    else $error("watchdog tick not from slow RC");
  a_sleep_choice: assert property (sleep_cmd && ce |=> enter_idle != enter_sleep)
    else $error("sleep command not answered once");
  a_one_run_flag: assert property
    (!(startup_timer_done_flag && timer_osc_running_flag))
    else $error("both running flags set");
  a_timer_flag_src: assert property
    (timer_osc_running_flag && !clock_hold |-> active_source == SRC_TIMEROSC)
    else $error("timer flag without timer source");
  a_startup_src: assert property
    (startup_timer_done_flag && !clock_hold |-> active_source == SRC_PRIMARY)
    else $error("startup flag without primary source");
endmodule : sclk_properties

bind sclk_top sclk_properties sclk_properties_inst (.pclk, .presetn, .ce, .psel, .penable,
  .pready, .slow_rc_osc_tick, .wdt_failsafe_clock_monitor_tick, .sleep_cmd, .enter_idle, .enter_sleep,
  .startup_timer_done_flag, .timer_osc_running_flag, .active_source, .clock_hold);

// ### bench/sclk_top_tb.sv
// Self-checking testbench for the clock select block
`timescale 1ns/1ps
module sclk_top_tb;
  import sclk_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        sleep_cmd = 1'b0;
  logic        ce = 1'b1;
  logic        power_managed_ok;
  logic        tmr_on = 1'b0;
  logic [2:0]  primary_mode = 3'h2;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'h32;
  logic [31:0] prdata, rd, r;
  logic        pready, pslverr, err, pri_t, tmr_t, fast_t, slow_t, clock_hold;
  logic [1:0]  active_source;
  logic        internal_tick, wdt_failsafe_clock_monitor_tick, enter_idle, enter_sleep, usb_low_speed;
  logic        startup_timer_done_flag, timer_osc_running_flag, multiplier_from_internal;
  logic [2:0]  multiplier_divisor;
  int          n_errors = 0;
  int          checks = 0;
  int          i, e, n_int, n_fast, n_slow, n_wdt;

  always #2.5 pclk = ~pclk;

  sclk_top sclk_top_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .primary_mode, .primary_tick(pri_t),
    .timer_osc_tick(tmr_t), .timer_osc_enabled(tmr_on), .fast_internal_osc_tick(fast_t),
    .slow_rc_osc_tick(slow_t), .sleep_cmd, .active_source, .clock_hold, .internal_tick,
    .wdt_failsafe_clock_monitor_tick, .startup_timer_done_flag, .timer_osc_running_flag, .enter_idle,
    .enter_sleep, .power_managed_ok, .usb_low_speed, .multiplier_from_internal,
    .multiplier_divisor);
  sclk_osc_model sclk_osc_model_inst (.pclk, .presetn, .tmr_on, .pri_t, .tmr_t, .fast_t,
    .slow_t);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] ctrl(logic idle, logic [2:0] f, logic [1:0] s);
    return {24'h0, idle, f, 2'h0, s};
  endfunction : ctrl
  function automatic logic [2:0] divisor(logic [2:0] c);
    return (c >= 3'h3) ? 3'h7 - c + 3'h1 : 3'h0;
  endfunction : divisor

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task give_up(input bit hit);
    if (hit)
    begin
      n_errors++;
      results();
    end
  endtask : give_up
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    give_up(t >= 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_src(input logic [1:0] s);
    int t;
    repeat (4) @(posedge pclk);
    for (t = 0; t < 400; t++)
    begin
      @(posedge pclk);
      if (active_source === s && clock_hold === 1'b0) break;
    end
    give_up(t >= 400);
  endtask : wait_src
  task count_ticks;
    n_int = 0;
    n_fast = 0;
    n_slow = 0;
    n_wdt = 0;
    repeat (8) @(posedge pclk);
    repeat (2048)
    begin
      @(posedge pclk);
      n_int += internal_tick;
      n_fast += fast_t;
      n_slow += slow_t;
      n_wdt += wdt_failsafe_clock_monitor_tick;
    end
  endtask : count_ticks

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OSC_CONTROL_REG_ADDR, 32'h0);
    check(32'(rd[6:4]), 32'(IFS_RESET));
    check(32'(rd[1:0]), 32'(SRC_RESET));
    check(32'(multiplier_divisor), 32'h1);
    check(32'(power_managed_ok), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1);
    for (i = 0; i < 4000; i++)
    begin
      @(posedge pclk);
      if (startup_timer_done_flag === 1'b1) break;
    end
    give_up(i >= 4000);
    check(32'(i > 3000), 32'h1);
    for (i = 1; i < 3; i++)
    begin
      apb(1'b1, OSC_CONTROL_REG_ADDR, ctrl(1'b0, 3'h6, i[1:0]));
      apb(1'b0, OSC_CONTROL_REG_ADDR, 32'h0);
      check(32'(rd[1:0]), 32'(SRC_PRIMARY));
    end
    tmr_on <= 1'b1;
    apb(1'b1, OSC_CONTROL_REG_ADDR, ctrl(1'b0, 3'h6, SRC_TIMEROSC));
    wait_src(SRC_TIMEROSC);
    check({startup_timer_done_flag, timer_osc_running_flag}, 32'h1);
    check(32'(power_managed_ok), 32'h1);
    apb(1'b1, OSC_CONTROL_REG_ADDR, ctrl(1'b0, 3'h7, SRC_INTERNAL));
    wait_src(SRC_INTERNAL);
    check(32'(timer_osc_running_flag), 32'h0);
    for (i = 0; i < 9; i++)
    begin
      apb(1'b1, OSC_TUNING_REG_ADDR, {24'h0, i == 8, 7'h0});
      apb(1'b1, OSC_CONTROL_REG_ADDR, ctrl(1'b0, i[2:0], SRC_INTERNAL));
      count_ticks();
      e = (i == 0) ? n_slow : n_fast >> ((i == 8) ? 8 : 7 - i);
      check(32'(n_int <= e + 1 && n_int >= e - 1), 32'h1);
      check(32'(n_wdt <= n_slow + 1 && n_wdt >= n_slow - 1), 32'h1);
    end
    for (i = 0; i < 6; i++)
    begin
      r = xs();
      apb(1'b1, OSC_CONTROL_REG_ADDR, ctrl(r[0], 3'h6, SRC_INTERNAL));
      sleep_cmd <= 1'b1;
      @(posedge pclk);
      sleep_cmd <= 1'b0;
      #1;
      check({enter_idle, enter_sleep}, {r[0], !r[0]});
    end
    // Clock enable low: a sleep command must leave the pulses frozen
    @(posedge pclk);
    ce <= 1'b0;
    sleep_cmd <= 1'b1;
    repeat (3) @(posedge pclk);
    check({enter_idle, enter_sleep}, 32'h0);
    ce <= 1'b1;
    sleep_cmd <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      r = (i == 0) ? 32'h67 : xs();
      primary_mode <= r[9:7];
      apb(1'b1, OSC_TUNING_REG_ADDR, r & 32'h40);
      apb(1'b1, USB_CFG_ADDR, r & 32'h37);
      repeat (2) @(posedge pclk);
      check(32'(multiplier_divisor), 32'(divisor(r[2:0])));
      check(32'(usb_low_speed), 32'(r[6] && r[5:4] == 2'h2));
      check(32'(multiplier_from_internal), 32'(r[6] && r[9:7] < 3'h2));
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OSC_CONTROL_REG_ADDR, 32'h0);
    check({rd[6:4], rd[1:0]}, {IFS_RESET, SRC_RESET});
    check(32'(active_source), 32'(SRC_PRIMARY));
    results();
  end
endmodule : sclk_top_tb

// ### core/sclk_pkg.sv
// Package: constants for the system clock source select block
//------------------------------------------------------------
// How it works
// - Low-speed USB needs 24 MHz system clock with 6 MHz USB clock.
// - All other system clock rates imply full-speed USB with 48 MHz USB clock.
// - Fast internal 8 MHz oscillator may feed the 96 MHz multiplier for USB.
// - Three source classes: primary, secondary timer oscillator, internal block.
// - Primary oscillator mode comes from a three-bit configuration field.
// - Power-managed modes need an alternate source; timer oscillator may keep running.
// - Two-bit source select picks primary, timer oscillator or postscaled internal.
// - Writing source select switches the clock at once after a short transition.
// - Every reset clears source select, restarting on the primary source.
// - Three-bit frequency select picks slow RC, 8 MHz, or 31 kHz..4 MHz tap.
// - Frequency select changes take effect immediately on the internal clock.
// - Internal postscaler defaults to 4 MHz on any reset.
// - At code 000 low-freq bit picks fast osc /256 or slow RC.
// - Watchdog and fail-safe monitor always run from the slow RC oscillator.
// - Startup flag set once startup timer expires and primary clock drives device.
// - Timer-osc-running flag set while timer oscillator supplies the device clock.
// - At most one running flag set; neither means internal source, switching or stabilising.
// - Idle-on-sleep bit chooses Idle versus Sleep on the sleep instruction.
// - Source encoding: 11 internal, 10 reserved, 01 timer osc, 00 primary.
// - Frequency codes 111 8 MHz down through halvings to 001 125 kHz, then 000 31 kHz.
// - Switch pauses clock two old cycles plus four new cycles.
//------------------------------------------------------------
package sclk_pkg;
  // Register byte addresses
  localparam logic [11:0] OSC_CONTROL_REG_ADDR = 12'h000;
  localparam logic [11:0] OSC_TUNING_REG_ADDR  = 12'h004;
  localparam logic [11:0] CLK_STATUS_ADDR      = 12'h008;
  localparam logic [11:0] USB_CFG_ADDR         = 12'h00c;
  // Control and tuning register fields
  localparam int IDLE_BIT    = 7;
  localparam int IFS_LSB     = 4;
  localparam int STARTUP_BIT = 3;
  localparam int UNIMPL_BIT  = 2;
  localparam int SRC_LSB     = 0;
  localparam int LFSRC_BIT   = 7;
  // Reset values
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [2:0] IFS_RESET = 3'h6;
  // Source encodings
  localparam logic [1:0] SRC_PRIMARY  = 2'h0;
  localparam logic [1:0] SRC_TIMEROSC = 2'h1;
  localparam logic [1:0] SRC_RESERVED = 2'h2;
  localparam logic [1:0] SRC_INTERNAL = 2'h3;
  // Frequency select: 111 direct, 000 lowest tap
  localparam logic [2:0] IFS_DIRECT = 3'h7;
  localparam logic [2:0] IFS_LOWEST = 3'h0;
  localparam logic [7:0] LF_DIVIDE  = 8'hff;
  // Primary mode field codes with multiplier
  localparam logic [2:0] PMODE_INT_A = 3'h0;
  localparam logic [2:0] PMODE_INT_B = 3'h1;
  // Multiplier prescale and cpu divider
  localparam logic [1:0] CPUDIV_BY2 = 2'h2;
  localparam logic [1:0] CPUDIV_1   = 2'h3;
  localparam int unsigned SYS_LOWSPEED_MHZ = 24;
  localparam int unsigned USB_LOW_MHZ      = 6;
  localparam int unsigned USB_FULL_MHZ     = 48;
  // Switch timing: old-source cycles and new-source cycles
  localparam logic [2:0] OLD_CYCLES = 3'h2;
  localparam logic [2:0] NEW_CYCLES = 3'h4;
  // Startup timer length in primary clock edges
  localparam logic [10:0] OST_CYCLES = 11'h400;
endpackage : sclk_pkg

// ### core/sclk_switch.sv
// Glitch-free source switch sequencer
`timescale 1ns/1ps
module sclk_switch
  import sclk_pkg::*;
(
  input  wire logic       pclk,         // System clock
  input  wire logic       presetn,      // Async reset, active low
  input  wire logic       ce,           // Clock enable
  input  wire logic [1:0] want_src,     // Requested source
  input  wire logic       old_tick,     // Edge of currently used source
  input  wire logic       new_tick,     // Edge of requested source
  output logic      [1:0] active_src,   // Source now driving the clock
  output logic            hold          // Device clock paused
);
  typedef enum logic [1:0] {IDLE, DRAIN_OLD, FILL_NEW} sclk_sw_type;
  sclk_sw_type st_q;
  logic [2:0]  cnt_q;

  //------------------------------------------------------------
  // Pause two old cycles then four new cycles
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= IDLE;
      cnt_q      <= 3'h0;
      active_src <= SRC_RESET;
      hold       <= 1'b0;
    end
    else if (ce)
    begin
      unique case (st_q)
        IDLE:
        begin
          if (want_src != active_src)
          begin
            st_q  <= DRAIN_OLD;
            cnt_q <= 3'h0;
            hold  <= 1'b1;
          end
        end
        DRAIN_OLD:
        begin
          if (old_tick)
          begin
            if (cnt_q == OLD_CYCLES - 3'h1)
            begin
              st_q       <= FILL_NEW;
              cnt_q      <= 3'h0;
              active_src <= want_src;
            end
            else
              cnt_q <= cnt_q + 3'h1;
          end
        end
        FILL_NEW:
        begin
          if (new_tick)
          begin
            if (cnt_q == NEW_CYCLES - 3'h1)
            begin
              st_q <= IDLE;
              hold <= 1'b0;
            end
            else
              cnt_q <= cnt_q + 3'h1;
          end
        end
      endcase
    end
  end
endmodule : sclk_switch

// ### core/sclk_top.sv
// System clock source select with APB registers
`timescale 1ns/1ps
module sclk_top
  import sclk_pkg::*;
(
  input  wire logic        pclk,                      // APB clock, 200 MHz
  input  wire logic        presetn,                   // Async reset, active low
  input  wire logic        ce,                        // Clock enable
  input  wire logic        psel,                      // APB select
  input  wire logic        penable,                   // APB enable
  input  wire logic        pwrite,                    // APB write
  input  wire logic [11:0] paddr,                     // APB byte address
  input  wire logic [31:0] pwdata,                    // APB write data
  output logic      [31:0] prdata,                    // APB read data
  output logic             pready,                    // APB ready
  output logic             pslverr,                   // APB error
  input  wire logic [2:0]  primary_mode,              // Primary mode config field
  input  wire logic        primary_tick,              // Primary oscillator edge
  input  wire logic        timer_osc_tick,            // Timer oscillator edge
  input  wire logic        timer_osc_enabled,         // Timer oscillator running
  input  wire logic        fast_internal_osc_tick,    // 8 MHz oscillator edge
  input  wire logic        slow_rc_osc_tick,          // Slow RC edge
  input  wire logic        sleep_cmd,                 // Sleep instruction pulse
  output logic      [1:0]  active_source,             // Source on device clock
  output logic             clock_hold,                // Device clock paused
  output logic             internal_tick,             // Postscaled internal edge
  output logic             wdt_failsafe_clock_monitor_tick,             // Watchdog / monitor edge
  output logic             startup_timer_done_flag,   // Primary up and used
  output logic             timer_osc_running_flag,    // Timer osc used
  output logic             enter_idle,                // Idle entry pulse
  output logic             enter_sleep,               // Sleep entry pulse
  output logic             power_managed_ok,          // Alternate source available
  output logic             usb_low_speed,             // Low-speed USB clocking valid
  output logic             multiplier_from_internal,  // 8 MHz feeds multiplier
  output logic      [2:0]  multiplier_divisor         // Prescale divide value
);
  import sclk_pkg::*;

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  logic       idle_on_sleep_bit_q;
  logic [2:0] internal_freq_select_q;
  logic [1:0] system_source_select_q;
  logic       low_freq_source_bit_q;
  logic       multiplier_en_q;
  logic [2:0] multiplier_prescale_q;
  logic [1:0] cpu_clock_divider_q;
  logic [10:0] ost_cnt_q;
  logic       ost_done_q;
  logic [7:0] post_cnt_q;
  logic [7:0] lf_cnt_q;
  logic       sw_hold;
  logic [1:0] sw_src;
  logic       old_tick;
  logic       new_tick;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  function automatic logic tick_of(input logic [1:0] s, input logic p, input logic t,
                                   input logic i);
    unique case (s)
      SRC_PRIMARY:  tick_of = p;
      SRC_TIMEROSC: tick_of = t;
      SRC_INTERNAL: tick_of = i;
      default:      tick_of = 1'b0;
    endcase
  endfunction : tick_of

  assign addr_ok = (paddr == OSC_CONTROL_REG_ADDR) || (paddr == OSC_TUNING_REG_ADDR) ||
                   (paddr == CLK_STATUS_ADDR) || (paddr == USB_CFG_ADDR);
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && !penable && !pwrite && ce;

  //------------------------------------------------------------
  // APB write side
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_on_sleep_bit_q    <= 1'b0;
      internal_freq_select_q <= IFS_RESET;
      system_source_select_q <= SRC_RESET;
    end
    else if (wr_en && paddr == OSC_CONTROL_REG_ADDR)
    begin
      idle_on_sleep_bit_q    <= pwdata[IDLE_BIT];
      internal_freq_select_q <= pwdata[IFS_LSB +: 3];
      // Reserved code and a stopped timer oscillator are not accepted
      if (pwdata[SRC_LSB +: 2] != SRC_RESERVED &&
          !(pwdata[SRC_LSB +: 2] == SRC_TIMEROSC && !timer_osc_enabled))
        system_source_select_q <= pwdata[SRC_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_freq_source_bit_q <= 1'b0;
      multiplier_en_q       <= 1'b0;
    end
    else if (wr_en && paddr == OSC_TUNING_REG_ADDR)
    begin
      low_freq_source_bit_q <= pwdata[LFSRC_BIT];
      multiplier_en_q       <= pwdata[LFSRC_BIT - 1];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      multiplier_prescale_q <= 3'h7;
      cpu_clock_divider_q   <= CPUDIV_1;
    end
    else if (wr_en && paddr == USB_CFG_ADDR)
    begin
      multiplier_prescale_q <= pwdata[2:0];
      cpu_clock_divider_q   <= pwdata[5:4];
    end
  end

  //------------------------------------------------------------
  // APB read side and answer
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en)
      begin
        unique case (paddr)
          OSC_CONTROL_REG_ADDR:
            prdata <= {24'h0, idle_on_sleep_bit_q, internal_freq_select_q,
                       startup_timer_done_flag, 1'b1, system_source_select_q};
          OSC_TUNING_REG_ADDR:
            prdata <= {24'h0, low_freq_source_bit_q, multiplier_en_q, 6'h0};
          CLK_STATUS_ADDR:
            prdata <= {26'h0, timer_osc_running_flag, clock_hold, active_source,
                       power_managed_ok, usb_low_speed};
          USB_CFG_ADDR:
            prdata <= {26'h0, cpu_clock_divider_q, 1'b0, multiplier_prescale_q};
          default:
            prdata <= 32'h0;
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // Internal postscaler and low-frequency source
  //------------------------------------------------------------
  // Postscaler bits that must all be set for one output tick
  function automatic logic [7:0] tap_mask(input logic [2:0] f);
    tap_mask = (8'h1 << (3'h7 - f)) - 8'h1;
  endfunction : tap_mask

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      post_cnt_q <= 8'h0;
      lf_cnt_q   <= 8'h0;
    end
    else if (ce && fast_internal_osc_tick)
    begin
      post_cnt_q <= post_cnt_q + 8'h1;
      lf_cnt_q   <= lf_cnt_q + 8'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_failsafe_clock_monitor_tick <= 1'b0;
    else if (ce)
      wdt_failsafe_clock_monitor_tick <= slow_rc_osc_tick;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      internal_tick <= 1'b0;
    else if (ce)
    begin
      // Tap chosen combinationally each cycle, so a new code acts at once
      if (internal_freq_select_q == IFS_DIRECT)
        internal_tick <= fast_internal_osc_tick;
      else if (internal_freq_select_q == IFS_LOWEST)
        internal_tick <= low_freq_source_bit_q ?
                         (fast_internal_osc_tick && lf_cnt_q == LF_DIVIDE) :
                         slow_rc_osc_tick;
      else
        internal_tick <= fast_internal_osc_tick &&
                         (post_cnt_q & tap_mask(internal_freq_select_q)) ==
                         tap_mask(internal_freq_select_q);
    end
  end

  //------------------------------------------------------------
  // Source switch and start-up timer
  //------------------------------------------------------------
  assign old_tick = tick_of(sw_src, primary_tick, timer_osc_tick, internal_tick);
  assign new_tick = tick_of(system_source_select_q, primary_tick, timer_osc_tick,
                            internal_tick);

  sclk_switch u_switch (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .want_src   (system_source_select_q),
    .old_tick   (old_tick),
    .new_tick   (new_tick),
    .active_src (sw_src),
    .hold       (sw_hold)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ost_cnt_q  <= 11'h0;
      ost_done_q <= 1'b0;
    end
    else if (ce && primary_tick && !ost_done_q)
    begin
      ost_cnt_q <= ost_cnt_q + 11'h1;
      if (ost_cnt_q == OST_CYCLES - 11'h1)
        ost_done_q <= 1'b1;
    end
  end

  //------------------------------------------------------------
  // Status flags and mode outputs
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_source <= SRC_RESET;
      clock_hold    <= 1'b0;
    end
    else if (ce)
    begin
      active_source <= sw_src;
      clock_hold    <= sw_hold;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      startup_timer_done_flag <= 1'b0;
      timer_osc_running_flag  <= 1'b0;
    end
    else if (ce)
    begin
      // Flags are mutually exclusive by construction of sw_src
      startup_timer_done_flag <= ost_done_q && sw_src == SRC_PRIMARY && !sw_hold;
      timer_osc_running_flag  <= sw_src == SRC_TIMEROSC && !sw_hold;
    end
  end

  //------------------------------------------------------------
  // Sleep decision and power-managed availability
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enter_idle  <= 1'b0;
      enter_sleep <= 1'b0;
    end
    else if (ce)
    begin
      enter_idle  <= sleep_cmd && idle_on_sleep_bit_q;
      enter_sleep <= sleep_cmd && !idle_on_sleep_bit_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      power_managed_ok <= 1'b0;
    else if (ce)
      power_managed_ok <= timer_osc_enabled ||
                          system_source_select_q == SRC_INTERNAL;
  end

  //------------------------------------------------------------
  // USB clocking checks
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_low_speed            <= 1'b0;
      multiplier_from_internal <= 1'b0;
    end
    else if (ce)
    begin
      // Only the cpu /2 from 48 MHz yields 24 MHz system with 6 MHz USB
      usb_low_speed <= multiplier_en_q && cpu_clock_divider_q == CPUDIV_BY2;
      multiplier_from_internal <= multiplier_en_q &&
        (primary_mode == PMODE_INT_A || primary_mode == PMODE_INT_B);
    end
  end

  //------------------------------------------------------------
  // Multiplier prescale decode
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      multiplier_divisor <= 3'h1;
    else if (ce)
      unique case (multiplier_prescale_q)
        3'h7:    multiplier_divisor <= 3'h1;
        3'h6:    multiplier_divisor <= 3'h2;
        3'h5:    multiplier_divisor <= 3'h3;
        3'h4:    multiplier_divisor <= 3'h4;
        3'h3:    multiplier_divisor <= 3'h5;
        default: multiplier_divisor <= 3'h0;
      endcase
  end
endmodule : sclk_top
